// File: efi_pkg.sv
/*
 * package for the e1 framer / data-link interrupt register block:
 * register offsets, bit positions, reset values and carrier structs.
 * assumes an apb slave with 32-bit data and one aligned word per register.
 */
package efi_pkg;

	// ==========================================================
	// register map: word indices; the byte address is four times the index
	// ==========================================================
	localparam logic [11:0] EFI_FRAMER_STATUS_OFS   = 12'hb04;
	localparam logic [11:0] EFI_FRAMER_IRQ_EN_OFS   = 12'hb05;
	localparam logic [11:0] EFI_DL_STATUS_ONE_OFS   = 12'hb06;
	localparam logic [11:0] EFI_DL_IRQ_EN_OFS       = 12'hb07;
	localparam logic [11:0] EFI_IRQ_STATUS_OFS      = 12'hb08;
	localparam logic [11:0] EFI_IRQ_CLEAR_OFS       = 12'hb09;
	localparam logic [11:0] EFI_IRQ_ENABLE_OFS      = 12'hb0a;
	localparam int          EFI_CHAN_LSB            = 14;

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int EFI_FRAME_LOSS_BIT   = 3;
	localparam int EFI_IMITATION_BIT    = 2;
	localparam int EFI_CHECKSUM_BIT     = 1;
	localparam int EFI_ALIGN_BIT        = 0;
	localparam int EFI_KIND_BIT         = 7;
	localparam int EFI_TX_BEGIN_BIT     = 6;
	localparam int EFI_RX_BEGIN_BIT     = 5;
	localparam int EFI_TX_DONE_BIT      = 4;

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [7:0]  EFI_BYTE_RESET  = 8'h00;
	localparam logic [31:0] EFI_WORD_ZERO   = 32'h0000_0000;

	// sticky event sources of one channel
	typedef struct packed {
		logic frameLoss;
		logic imitation;
		logic checksumErr;
		logic alignErr;
		logic txBegin;
		logic rxBegin;
		logic txDone;
	} efi_events_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [17:0] paddr;
		logic [31:0] pwdata;
	} efi_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} efi_apb_rsp_t;

endpackage

// File: efi_sync3.sv
/*
 * three-flop synchroniser with agreement filter for one pin-level input.
 * assumes clk_sys domain; input may change at any time.
 */
`timescale 1ns/1ps
module efi_sync3 (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic pinIn,
	output logic      levelOut
);
	import efi_pkg::*;

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;

	// ==========================================================
	// sampling chain
	// ==========================================================
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
		end else if (clkEn) begin
			stage1_reg <= pinIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// a change only counts once the later two stages agree
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			levelOut <= 1'b0;
		end else if (clkEn && (stage2_reg == stage3_reg)) begin
			levelOut <= stage3_reg;
		end
	end
endmodule // efi_sync3

// File: efi_edge_latch.sv
/*
 * sticky status bit set by a one-cycle event, cleared by a clear pulse.
 * assumes event and clear are both on clk_sys; set beats clear.
 */
`timescale 1ns/1ps
module efi_edge_latch (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic eventPulse,
	input  wire logic clearPulse,
	output logic      stickyBit
);
	import efi_pkg::*;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stickyBit <= 1'b0;
		end else if (clkEn) begin
			if (eventPulse) begin
				stickyBit <= 1'b1;
			end else if (clearPulse) begin
				stickyBit <= 1'b0;
			end
		end
	end
endmodule // efi_edge_latch

// File: efi_irq_regs.sv
/*
 * per-channel interrupt register block of an e1 framer: framer interrupt
 * enables, framer status, first data-link status with its enables, and a
 * summary status/clear/enable triple driving one level interrupt.
 * assumes an apb master on clk_sys; framer and hdlc events arrive as
 * one-cycle pulses on clk_sys, frame loss as a level on clk_sys; the message-kind level comes from a pin.
 */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

module efi_irq_regs #(
	parameter int CHANNEL = 0
) (
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire logic                  clkEn,
	input  wire efi_pkg::efi_apb_req_t apbReq,
	output efi_pkg::efi_apb_rsp_t      apbRsp,
	input  wire logic                  frameLossState,
	input  wire logic                  imitationEvent,
	input  wire logic                  checksumErrEvent,
	input  wire logic                  alignErrEvent,
	input  wire logic                  linkMessageKindPin,
	input  wire logic                  txMessageBeginEvent,
	input  wire logic                  rxMessageBeginEvent,
	input  wire logic                  txMessageDoneEvent,
	output logic                       irqOut
);
	import efi_pkg::*;

	localparam logic [3:0] CHAN_ID = 4'(CHANNEL);

	logic [7:0]  framerIrqEn_reg;
	logic [7:0]  dlIrqEn_reg;
	logic [6:0]  summaryEn_reg;
	logic        frameLossPrev_reg;
	logic        linkMessageKind;
	logic [3:0]  framerSticky;
	logic [2:0]  dlSticky;
	logic [6:0]  summarySticky_reg;
	logic [6:0]  rawEvents;
	logic [6:0]  enabledEvents;
	logic        accessDone;
	logic        wrStrobe;
	logic        rdStrobe;
	logic        hitChan;
	logic [11:0] localAddr;
	logic        clrFramer;
	logic        clrDl;
	logic [31:0] readMux;
	logic        mapped;

	function automatic logic [7:0] efi_pack_byte(input logic [31:0] w);
		return w[7:0];
	endfunction

	// ==========================================================
	// bus decode: zero wait states, unmapped or unaligned returns pslverr
	// ==========================================================
	assign localAddr  = apbReq.paddr[13:2];
	assign hitChan    = (apbReq.paddr[17:EFI_CHAN_LSB] == CHAN_ID) && (apbReq.paddr[1:0] == 2'b00);
	assign accessDone = apbReq.psel && apbReq.penable && clkEn;
	assign wrStrobe   = accessDone && apbReq.pwrite && hitChan;
	assign rdStrobe   = accessDone && !apbReq.pwrite && hitChan;
	assign clrFramer  = rdStrobe && (localAddr == EFI_FRAMER_STATUS_OFS);
	assign clrDl      = rdStrobe && (localAddr == EFI_DL_STATUS_ONE_OFS);

	// ==========================================================
	// event sources
	// ==========================================================
	efi_sync3 u_kindSync (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.clkEn    (clkEn),
		.pinIn    (linkMessageKindPin),
		.levelOut (linkMessageKind)
	);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			frameLossPrev_reg <= 1'b0;
		end else if (clkEn) begin
			frameLossPrev_reg <= frameLossState;
		end
	end

	// both the declaring and clearing edge count as a change
	assign rawEvents[6] = frameLossState ^ frameLossPrev_reg;
	assign rawEvents[5] = imitationEvent;
	assign rawEvents[4] = checksumErrEvent;
	assign rawEvents[3] = alignErrEvent;                      // framer sync untouched
	assign rawEvents[2] = txMessageBeginEvent;
	assign rawEvents[1] = rxMessageBeginEvent;
	assign rawEvents[0] = txMessageDoneEvent;

	// ==========================================================
	// sticky status, cleared by reading its register
	// ==========================================================
	// only bits the reader has already seen are cleared, so an event that
	// lands between setup and access is not lost
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_framer
			efi_edge_latch u_latch (
				.clk_sys    (clk_sys),
				.resetn     (resetn),
				.clkEn      (clkEn),
				.eventPulse (rawEvents[3+gi]),
				.clearPulse (clrFramer && apbRsp.prdata[gi]),
				.stickyBit  (framerSticky[gi])
			);
		end
		for (gi = 0; gi < 3; gi++) begin : g_dl
			efi_edge_latch u_latch (
				.clk_sys    (clk_sys),
				.resetn     (resetn),
				.clkEn      (clkEn),
				.eventPulse (rawEvents[gi]),
				.clearPulse (clrDl && apbRsp.prdata[4+gi]),
				.stickyBit  (dlSticky[gi])
			);
		end
	endgenerate

	// ==========================================================
	// software-written enables
	// ==========================================================
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			framerIrqEn_reg <= EFI_BYTE_RESET;
			dlIrqEn_reg     <= EFI_BYTE_RESET;
			summaryEn_reg   <= 7'h00;
		end else if (wrStrobe) begin
			case (localAddr)
				EFI_FRAMER_IRQ_EN_OFS: begin
					framerIrqEn_reg <= efi_pack_byte(apbReq.pwdata);
				end
				EFI_DL_IRQ_EN_OFS: begin
					dlIrqEn_reg <= {1'b0, apbReq.pwdata[6:4], 4'h0};
				end
				EFI_IRQ_ENABLE_OFS: begin
					summaryEn_reg <= apbReq.pwdata[6:0];
				end
				default: begin
				end
			endcase
		end
	end

	// per-source enable gating; a disabled source never reaches the summary
	assign enabledEvents = {
		rawEvents[6] & framerIrqEn_reg[EFI_FRAME_LOSS_BIT],
		rawEvents[5] & framerIrqEn_reg[EFI_IMITATION_BIT],
		rawEvents[4] & framerIrqEn_reg[EFI_CHECKSUM_BIT],
		rawEvents[3] & framerIrqEn_reg[EFI_ALIGN_BIT],
		rawEvents[2] & dlIrqEn_reg[EFI_TX_BEGIN_BIT],
		rawEvents[1] & dlIrqEn_reg[EFI_RX_BEGIN_BIT],
		rawEvents[0] & dlIrqEn_reg[EFI_TX_DONE_BIT]
	};

	// summary status: write-one-to-clear; a new event in the same cycle wins
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			summarySticky_reg <= 7'h00;
		end else if (clkEn) begin
			if (wrStrobe && (localAddr == EFI_IRQ_CLEAR_OFS)) begin
				summarySticky_reg <= (summarySticky_reg & ~apbReq.pwdata[6:0]) | enabledEvents;
			end else begin
				summarySticky_reg <= summarySticky_reg | enabledEvents;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irqOut <= 1'b0;
		end else if (clkEn) begin
			irqOut <= |(summarySticky_reg & summaryEn_reg);
		end
	end

	// ==========================================================
	// read path
	// ==========================================================
	always_comb begin
		readMux = EFI_WORD_ZERO;
		mapped  = 1'b1;
		case (localAddr)
			EFI_FRAMER_IRQ_EN_OFS: readMux[7:0] = framerIrqEn_reg;
			EFI_DL_STATUS_ONE_OFS: readMux[7:0] = {linkMessageKind, dlSticky, 4'h0};
			EFI_DL_IRQ_EN_OFS:     readMux[7:0] = dlIrqEn_reg;
			EFI_FRAMER_STATUS_OFS: readMux[7:0] = {4'h0, framerSticky};
			EFI_IRQ_STATUS_OFS:    readMux[6:0] = summarySticky_reg;
			EFI_IRQ_CLEAR_OFS:     readMux      = EFI_WORD_ZERO;
			EFI_IRQ_ENABLE_OFS:    readMux[6:0] = summaryEn_reg;
			default:               mapped       = 1'b0;
		endcase
	end

	// response registered on the setup cycle so it stands during access
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			apbRsp <= '0;
		end else if (clkEn) begin
			apbRsp.pready  <= apbReq.psel && !apbReq.penable;
			apbRsp.pslverr <= apbReq.psel && !apbReq.penable && !(mapped && hitChan);
			if (apbReq.psel && !apbReq.penable && !apbReq.pwrite && hitChan) begin
				apbRsp.prdata <= readMux;
			end else begin
				apbRsp.prdata <= EFI_WORD_ZERO;
			end
		end
	end
endmodule // efi_irq_regs

// File: efi_irq_chk.sv
/*
 * port checker for efi_irq_regs, bound at the foot of this file.
 * assumes one clock domain and the registered bus answer of the block.
 */
`timescale 1ns/1ps
module efi_irq_chk #(parameter int CHANNEL = 0) (
	input wire logic                  clk_sys,
	input wire logic                  resetn,
	input wire logic                  clkEn,
	input wire efi_pkg::efi_apb_req_t apbReq,
	input wire efi_pkg::efi_apb_rsp_t apbRsp,
	input wire logic                  linkMessageKindPin,
	input wire logic                  irqOut
);
	import efi_pkg::*;
	// ==========================================
	// sequences and properties
	// ==========================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_setup;
		apbReq.psel && !apbReq.penable && clkEn;
	endsequence
	// the pin passes a synchroniser, so it must settle first
	sequence s_kindSettled;
		(clkEn && $stable(linkMessageKindPin))[*8];
	endsequence
	property p_readyAfterSetup;
		s_setup |=> apbRsp.pready;
	endproperty
	property p_readyOneCycle;
		apbRsp.pready && clkEn |=> !apbRsp.pready;
	endproperty
	property p_wrongChannel;
		s_setup ##0 (apbReq.paddr[17:14] != 4'(CHANNEL))
			|=> apbRsp.pslverr && apbRsp.prdata == 32'h0000_0000;
	endproperty
	property p_writeNoData;
		s_setup ##0 apbReq.pwrite |=> apbRsp.prdata == 32'h0000_0000;
	endproperty
	property p_upperZero;
		apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h00_0000;
	endproperty
	property p_kindReadback;
		s_kindSettled ##0 s_setup
			##0 (!apbReq.pwrite && apbReq.paddr == {4'(CHANNEL), EFI_DL_STATUS_ONE_OFS, 2'b00})
			|=> apbRsp.prdata[7] == $past(linkMessageKindPin);
	endproperty
	// only a clear or mask write may drop the request
	property p_irqFall;
		$fell(irqOut) |-> $past(apbReq.psel && apbReq.pwrite, 1)
			|| $past(apbReq.psel && apbReq.pwrite, 2) || $past(apbReq.psel && apbReq.pwrite, 3);
	endproperty
	property p_freeze;
		!clkEn |=> $stable(irqOut) && $stable(apbRsp);
	endproperty
	a_readyAfterSetup: assert property (p_readyAfterSetup) else $error("no ready after setup");
	a_readyOneCycle: assert property (p_readyOneCycle) else $error("ready held too long");
	a_wrongChannel: assert property (p_wrongChannel) else $error("foreign channel accepted");
	a_writeNoData: assert property (p_writeNoData) else $error("data on write");
	a_upperZero: assert property (p_upperZero) else $error("upper read bits set");
	a_kindReadback: assert property (p_kindReadback) else $error("message kind wrong");
	a_irqFall: assert property (p_irqFall) else $error("irq dropped by itself");
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule // efi_irq_chk

bind efi_irq_regs efi_irq_chk #(.CHANNEL(CHANNEL)) efi_irq_chk_i (
	.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
	.linkMessageKindPin(linkMessageKindPin), .irqOut(irqOut));

// File: testbench.sv
/*
 * self-checking bench for efi_irq_regs on channel 5.
 * assumes the bound checker and a 100 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
	import efi_pkg::*;
	localparam int CH = 5;
	logic         clk_sys = 1'b0;
	logic         resetn = 1'b0;
	logic         clkEn = 1'b1;
	efi_apb_req_t apbReq = '0;
	efi_apb_rsp_t apbRsp;
	logic         frameLossState = 1'b0;
	logic         imitationEvent = 1'b0;
	logic         checksumErrEvent = 1'b0;
	logic         alignErrEvent = 1'b0;
	logic         linkMessageKindPin = 1'b0;
	logic         txMessageBeginEvent = 1'b0;
	logic         rxMessageBeginEvent = 1'b0;
	logic         txMessageDoneEvent = 1'b0;
	logic         irqOut;
	int           failures = 0;
	int           tests_run = 0;
	int           cycles = 0;
	efi_irq_regs #(.CHANNEL(CH)) efi_irq_regs_i (.clk_sys(clk_sys), .resetn(resetn),
		.clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp), .frameLossState(frameLossState),
		.imitationEvent(imitationEvent), .checksumErrEvent(checksumErrEvent),
		.alignErrEvent(alignErrEvent), .linkMessageKindPin(linkMessageKindPin),
		.txMessageBeginEvent(txMessageBeginEvent), .rxMessageBeginEvent(rxMessageBeginEvent),
		.txMessageDoneEvent(txMessageDoneEvent), .irqOut(irqOut));
	always #5 clk_sys = ~clk_sys;
	// ==========================================
	// helpers
	// ==========================================
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// idle cycle first, so no two transfers touch the same edge
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk_sys);
		apbReq <= {1'b1, 1'b0, w, a, d};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
	endtask
	task automatic rdc(input logic [11:0] ofs, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] d;
		logic        e;
		apb(1'b0, {4'(CH), ofs, 2'b00}, 32'h0000_0000, d, e);
		chk(d & m, exp);
	endtask
	task automatic wr(input logic [11:0] ofs, input logic [31:0] v);
		logic [31:0] d;
		logic        e;
		apb(1'b1, {4'(CH), ofs, 2'b00}, v, d, e);
	endtask
	task automatic fire(input int i);
		@(posedge clk_sys);
		case (i)
			0: frameLossState <= ~frameLossState;
			1: imitationEvent <= 1'b1;
			2: checksumErrEvent <= 1'b1;
			3: alignErrEvent <= 1'b1;
			4: txMessageBeginEvent <= 1'b1; // host may refill the next buffer from here
			5: rxMessageBeginEvent <= 1'b1;
			default: txMessageDoneEvent <= 1'b1; // next buffer counted as loaded
		endcase
		@(posedge clk_sys);
		{imitationEvent, checksumErrEvent, alignErrEvent} <= '0;
		{txMessageBeginEvent, rxMessageBeginEvent, txMessageDoneEvent} <= '0;
	endtask
	// ==========================================
	// scenarios
	// ==========================================
	task automatic t_reset;
		logic [11:0] ofs [7] = '{EFI_FRAMER_IRQ_EN_OFS, EFI_DL_STATUS_ONE_OFS, EFI_DL_IRQ_EN_OFS,
			EFI_FRAMER_STATUS_OFS, EFI_IRQ_STATUS_OFS, EFI_IRQ_CLEAR_OFS, EFI_IRQ_ENABLE_OFS};
		foreach (ofs[k]) rdc(ofs[k], 32'hFFFF_FFFF, 32'h0000_0000);
		wr(EFI_FRAMER_IRQ_EN_OFS, 32'h0000_005A);
		rdc(EFI_FRAMER_IRQ_EN_OFS, 32'hFFFF_FFFF, 32'h0000_005A);
		wr(EFI_DL_IRQ_EN_OFS, 32'h0000_00FF);
		rdc(EFI_DL_IRQ_EN_OFS, 32'hFFFF_FFFF, 32'h0000_0070);
		wr(EFI_FRAMER_IRQ_EN_OFS, 32'h0000_0000);
		$display("done: reset and enables");
	endtask
	task automatic t_bus;
		logic [31:0] d;
		logic        e;
		apb(1'b1, {4'(CH + 1), EFI_FRAMER_IRQ_EN_OFS, 2'b00}, 32'h0000_00FF, d, e);
		chk(32'(e), 32'h0000_0001);
		apb(1'b0, {4'(CH), 12'hb00, 2'b00}, 32'h0000_0000, d, e);
		chk({d[30:0], e}, 32'h0000_0001);
		apb(1'b0, {4'(CH + 1), EFI_DL_IRQ_EN_OFS, 2'b00}, 32'h0000_0000, d, e);
		chk({d[30:0], e}, 32'h0000_0001);
		apb(1'b0, {4'(CH), EFI_DL_IRQ_EN_OFS, 2'b10}, 32'h0000_0000, d, e);
		chk({d[30:0], e}, 32'h0000_0001);
		rdc(EFI_FRAMER_IRQ_EN_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("done: refused accesses");
	endtask
	task automatic t_events;
		int          s;
		logic [11:0] ofs;
		logic [31:0] bit1;
		wr(EFI_FRAMER_IRQ_EN_OFS, 32'h0000_000F);
		wr(EFI_DL_IRQ_EN_OFS, 32'h0000_0070);
		wr(EFI_IRQ_ENABLE_OFS, 32'h0000_007F);
		// pass 7 sees the frame-loss level fall again
		for (int i = 0; i < 8; i++) begin
			s = i % 7;
			ofs = (s < 4) ? EFI_FRAMER_STATUS_OFS : EFI_DL_STATUS_ONE_OFS;
			bit1 = 32'h0000_0001 << ((s < 4) ? 3 - s : 10 - s);
			fire(s);
			cyc(3);
			chk(32'(irqOut), 32'h0000_0001);
			rdc(ofs, 32'h0000_007F, bit1);
			rdc(ofs, 32'h0000_007F, 32'h0000_0000);
			rdc(EFI_IRQ_STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0001 << (6 - s));
			wr(EFI_IRQ_CLEAR_OFS, 32'h0000_0001 << (6 - s));
			cyc(3);
			chk(32'(irqOut), 32'h0000_0000);
		end
		$display("done: every event source");
	endtask
	task automatic t_mask;
		wr(EFI_FRAMER_IRQ_EN_OFS, 32'h0000_000D);
		fire(2);
		cyc(3);
		rdc(EFI_IRQ_STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(EFI_FRAMER_IRQ_EN_OFS, 32'h0000_000F);
		wr(EFI_IRQ_ENABLE_OFS, 32'h0000_0000);
		fire(3);
		cyc(3);
		chk(32'(irqOut), 32'h0000_0000);
		rdc(EFI_IRQ_STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0008);
		wr(EFI_IRQ_ENABLE_OFS, 32'h0000_007F);
		cyc(3);
		chk(32'(irqOut), 32'h0000_0001);
		clkEn <= 1'b0;
		fire(1);
		cyc(2);
		chk(32'(irqOut), 32'h0000_0001);
		clkEn <= 1'b1;
		rdc(EFI_FRAMER_STATUS_OFS, 32'h0000_0004, 32'h0000_0000);
		wr(EFI_IRQ_CLEAR_OFS, 32'h0000_007F);
		cyc(3);
		chk(32'(irqOut), 32'h0000_0000);
		$display("done: masking and freeze");
	endtask
	task automatic t_kind;
		linkMessageKindPin <= 1'b1;
		cyc(12);
		rdc(EFI_DL_STATUS_ONE_OFS, 32'h0000_0080, 32'h0000_0080);
		rdc(EFI_DL_STATUS_ONE_OFS, 32'h0000_0080, 32'h0000_0080);
		linkMessageKindPin <= 1'b0;
		cyc(12);
		rdc(EFI_DL_STATUS_ONE_OFS, 32'h0000_0080, 32'h0000_0000);
		$display("done: message kind");
	endtask
	initial begin
		cyc(10);
		resetn <= 1'b1;
		t_reset();
		t_bus();
		t_events();
		t_mask();
		t_kind();
		summarize();
	end
endmodule // testbench
